// >>> verilog/scan_cycle_map.vh
// Register offsets, field positions, reset values and timing figures
// Included by the supervisor design files; definitions only
`ifndef SCAN_CYCLE_MAP_VH
`define SCAN_CYCLE_MAP_VH
// Byte addresses on the Avalon-MM register bus
`define REG_MIN_CYCLE 6'h00
`define REG_WATCH_CYCLE 6'h04
`define REG_MAX_DUR 6'h08
`define REG_PRESENT_DUR 6'h0c
`define REG_AVG_DUR 6'h10
`define REG_PERIPH_DUR 6'h14
`define REG_CONTROL 6'h18
`define REG_STATUS 6'h1c
`define REG_SCHED_PERIOD 6'h20
`define REG_TASK 6'h24
`define REG_EDGE_CFG 6'h28
`define REG_REFRESH_CFG 6'h2c
// Reset values
`define MIN_CYCLE_RST 16'h0000
`define WATCH_CYCLE_RST 16'h0001
`define SCHED_PERIOD_RST 16'h000a
// Field positions
`define WATCH_EN_BIT 15
`define WATCH_LIM_MSB 14
`define WATCH_LIM_MAX 15'h0fa0
`define MIN_CYCLE_MAX 16'h7d00
`define CTL_RUN 0
`define CTL_PARALLEL 1
`define CTL_CYCLE_END 2
`define CTL_PERIPH_END 3
`define CTL_CLEAR 4
`define ST_OVERRUN 0
`define ST_PERIPH_OVR 1
`define ST_SPECIAL_ERR 2
`define ST_PADDING 3
`define ST_RUNNING 4
// Timing figures
`define TICK_NS 100000
`define CLK_NS 10
`define MS_TICKS 10
`define WATCH_STEP_TICKS 100
`define DEFAULT_WATCH_TICKS 10000
`define PERIPH_LIMIT_TICKS 20000
`define AVG_DEPTH 8
`define AVG_SHIFT 3
// Task numbers
`define TASK_POWER_OFF 8'h01
`define TASK_SCHED_A 8'h02
`define TASK_SCHED_B 8'h03
`define TASK_IO_BASE 8'h64
`endif

// >>> verilog/edge_detector.v
// One interrupt input edge detector with selectable edge sense
// Assumes inputs synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module edge_detector (
  input wire mclk,
  input wire rst_b,
  input wire level,
  input wire both_edges,
  output reg pulse
);
  reg last;
  // Rising edge by default, either edge where the unit allows it
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      last <= 1'b0;
      pulse <= 1'b0;
    end else begin
      last <= level;
      pulse <= (level & ~last) | (both_edges & ~level & last);
    end
  end
endmodule
`default_nettype wire

// >>> verilog/scan_cycle_time_supervisor.v
// Scan cycle time supervisor: pads, watches and records execution cycles
// Assumes an Avalon-MM master and cycle boundary strobes from the executor
`timescale 1ns/1ps
`default_nettype none
`include "scan_cycle_map.vh"
module scan_cycle_time_supervisor #(
  parameter TICK_CYCLES = `TICK_NS / `CLK_NS,
  parameter IO_INTS = 32
) (
  input wire mclk,
  input wire rst_b,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire program_done,
  input wire periph_done,
  input wire special_busy,
  input wire power_fail,
  input wire [IO_INTS-1:0] io_int,
  input wire ext_int,
  input wire [7:0] ext_task,
  input wire task_ack,
  output reg cycle_start,
  output reg halted,
  output reg task_req,
  output reg [7:0] task_num,
  output reg [3:0] refresh_allow
);
  localparam [16:0] TICK_DIV = TICK_CYCLES;
  // Cycle phases
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_EXEC = 2'd1;
  localparam [1:0] S_PAD = 2'd2;
  localparam [1:0] S_HALT = 2'd3;

  reg [15:0] min_cycle;
  reg [15:0] watch_cycle;
  reg [31:0] max_dur;
  reg [31:0] present_dur;
  reg [31:0] periph_dur;
  reg [15:0] sched_period;
  reg [IO_INTS-1:0] edge_cfg;
  reg [3:0] special_refresh_off;
  reg run;
  reg parallel;
  reg overrun_flag;
  reg periph_overrun_flag;
  reg special_unit_error_flag;
  reg [1:0] state;
  reg [16:0] div;
  reg tick;
  reg [31:0] tick_count;
  reg [31:0] cycle_base;
  reg [31:0] periph_base;
  reg [31:0] hist [0:`AVG_DEPTH-1];
  reg [2:0] hist_ptr;
  reg [34:0] hist_sum;
  reg [15:0] sched_cnt;
  reg sched_sel;
  reg [IO_INTS-1:0] io_pend;
  reg pf_last;
  reg pf_pend;
  reg ext_pend;
  reg [7:0] ext_num;
  reg sched_pend;
  reg [7:0] sched_num;
  reg [31:0] next_readdata;
  wire [IO_INTS-1:0] io_pulse;
  wire [31:0] elapsed = tick_count - cycle_base;
  wire [31:0] periph_elapsed = tick_count - periph_base;
  wire [31:0] min_ticks = {16'h0000, min_cycle} * `MS_TICKS;
  wire [31:0] watch_ticks = watch_cycle[`WATCH_EN_BIT] ?
    {17'h00000, watch_cycle[`WATCH_LIM_MSB:0]} * `WATCH_STEP_TICKS :
    `DEFAULT_WATCH_TICKS;
  wire sw_cycle_end = avs_write && !avs_waitrequest && avs_address == `REG_CONTROL &&
    avs_writedata[`CTL_CYCLE_END];
  wire sw_periph_end = avs_write && !avs_waitrequest && avs_address == `REG_CONTROL &&
    avs_writedata[`CTL_PERIPH_END];
  // Program-only end in parallel mode, program plus servicing otherwise
  wire exec_end = parallel ? (program_done | sw_cycle_end) :
    (periph_done | sw_cycle_end);
  wire pad_needed = min_cycle != 16'h0000 && elapsed < min_ticks;
  integer i;

  genvar g;
  generate
    for (g = 0; g < IO_INTS; g = g + 1) begin : io_edges
      edge_detector u_edge (
        .mclk(mclk),
        .rst_b(rst_b),
        .level(io_int[g]),
        .both_edges(edge_cfg[g]),
        .pulse(io_pulse[g])
      );
    end
  endgenerate

  // Free-running 0.1 ms timebase shared by padding and watch checks
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div <= 17'h00000;
      tick <= 1'b0;
      tick_count <= 32'h00000000;
    end else begin
      tick <= 1'b0;
      if (div == TICK_DIV - 17'h00001) begin
        div <= 17'h00000;
        tick <= 1'b1;
        tick_count <= tick_count + 32'd1;
      end else begin
        div <= div + 17'h00001;
      end
    end
  end

  // Cycle sequencer: execute, pad to minimum, or halt on overrun
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      cycle_base <= 32'h00000000;
      periph_base <= 32'h00000000;
      cycle_start <= 1'b0;
      halted <= 1'b0;
      overrun_flag <= 1'b0;
      periph_overrun_flag <= 1'b0;
      special_unit_error_flag <= 1'b0;
      max_dur <= 32'h00000000;
      present_dur <= 32'h00000000;
      periph_dur <= 32'h00000000;
      hist_ptr <= 3'd0;
      hist_sum <= 35'h000000000;
      for (i = 0; i < `AVG_DEPTH; i = i + 1)
        hist[i] <= 32'h00000000;
    end else begin
      cycle_start <= 1'b0;
      // Refresh arriving while a special unit is still busy
      if (special_busy && (exec_end || sw_periph_end || periph_done) && state == S_EXEC)
        special_unit_error_flag <= 1'b1;
      else if (avs_write && !avs_waitrequest && avs_address == `REG_CONTROL &&
          avs_writedata[`CTL_CLEAR])
        special_unit_error_flag <= 1'b0;
      case (state)
        S_IDLE: begin
          if (run) begin
            state <= S_EXEC;
            cycle_start <= 1'b1;
            cycle_base <= tick_count;
            periph_base <= tick_count;
          end
        end
        S_EXEC: begin
          if (elapsed > watch_ticks) begin
            overrun_flag <= 1'b1;
            halted <= 1'b1;
            state <= S_HALT;
          end else if (parallel && periph_elapsed > `PERIPH_LIMIT_TICKS) begin
            periph_overrun_flag <= 1'b1;
            halted <= 1'b1;
            state <= S_HALT;
          end else if (exec_end) begin
            present_dur <= elapsed;
            if (elapsed > max_dur)
              max_dur <= elapsed;
            hist[hist_ptr] <= elapsed;
            hist_sum <= hist_sum + {3'b000, elapsed} - {3'b000, hist[hist_ptr]};
            hist_ptr <= hist_ptr + 3'd1;
            if (pad_needed) begin
              state <= S_PAD;
            end else begin
              cycle_base <= tick_count;
              cycle_start <= 1'b1;
              if (!run)
                state <= S_IDLE;
            end
          end
          // Servicing runs alongside program execution in parallel mode
          if (parallel && (periph_done || sw_periph_end)) begin
            periph_dur <= periph_elapsed;
            periph_base <= tick_count;
          end
        end
        S_PAD: begin
          if (elapsed >= min_ticks) begin
            cycle_base <= tick_count;
            cycle_start <= 1'b1;
            state <= run ? S_EXEC : S_IDLE;
          end
        end
        default: begin
          // Stays stopped until software clears the fault
          if (avs_write && !avs_waitrequest && avs_address == `REG_CONTROL &&
              avs_writedata[`CTL_CLEAR]) begin
            overrun_flag <= 1'b0;
            periph_overrun_flag <= 1'b0;
            halted <= 1'b0;
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Interrupt task dispatch; power-off first, then external, scheduled, I/O
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      task_req <= 1'b0;
      task_num <= 8'h00;
      io_pend <= {IO_INTS{1'b0}};
      pf_last <= 1'b0;
      pf_pend <= 1'b0;
      ext_pend <= 1'b0;
      ext_num <= 8'h00;
      sched_pend <= 1'b0;
      sched_num <= 8'h00;
      sched_cnt <= 16'h0000;
      sched_sel <= 1'b0;
    end else begin
      pf_last <= power_fail;
      if (power_fail && !pf_last)
        pf_pend <= 1'b1;
      if (ext_int && !ext_pend) begin
        ext_pend <= 1'b1;
        ext_num <= ext_task;
      end
      if (tick) begin
        if (sched_cnt + 16'h0001 >= sched_period) begin
          sched_cnt <= 16'h0000;
          sched_sel <= ~sched_sel;
          sched_pend <= 1'b1;
          sched_num <= sched_sel ? `TASK_SCHED_B : `TASK_SCHED_A;
        end else begin
          sched_cnt <= sched_cnt + 16'h0001;
        end
      end
      if (task_req) begin
        if (task_ack)
          task_req <= 1'b0;
      end else if (pf_pend) begin
        task_req <= 1'b1;
        task_num <= `TASK_POWER_OFF;
        pf_pend <= power_fail && !pf_last; // Fresh edge wins over the clear
      end else if (ext_pend) begin
        task_req <= 1'b1;
        task_num <= ext_num;
        ext_pend <= 1'b0;
      end else if (sched_pend && !(tick && sched_cnt + 16'h0001 >= sched_period)) begin
        task_req <= 1'b1;
        task_num <= sched_num;
        sched_pend <= 1'b0;
      end else begin
        for (i = IO_INTS - 1; i >= 0; i = i - 1) begin
          if (io_pend[i] && !task_req) begin
            task_req <= 1'b1;
            task_num <= `TASK_IO_BASE + i[7:0];
          end
        end
      end
      // New edges set, served line clears; set wins in the same cycle
      for (i = 0; i < IO_INTS; i = i + 1) begin
        if (io_pulse[i])
          io_pend[i] <= 1'b1;
        else if (!task_req && !pf_pend && !ext_pend && io_pend[i] &&
            !(sched_pend && !(tick && sched_cnt + 16'h0001 >= sched_period)) &&
            (io_pend & ((32'h1 << i) - 32'h1)) == 0)
          io_pend[i] <= 1'b0;
      end
    end
  end

  // Register writes and the one-wait-state bus answer
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      min_cycle <= `MIN_CYCLE_RST;
      watch_cycle <= `WATCH_CYCLE_RST;
      sched_period <= `SCHED_PERIOD_RST;
      edge_cfg <= {IO_INTS{1'b0}};
      special_refresh_off <= 4'h0;
      run <= 1'b0;
      parallel <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      refresh_allow <= 4'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      avs_readdata <= next_readdata;
      // Cyclic refresh for every class, special units maskable
      refresh_allow <= {1'b1, 1'b1, ~special_refresh_off[0], 1'b1};
      if (avs_write && !avs_waitrequest) begin
        if (avs_address == `REG_MIN_CYCLE) begin
          if (avs_writedata[15:0] <= `MIN_CYCLE_MAX)
            min_cycle <= avs_writedata[15:0];
        end else if (avs_address == `REG_WATCH_CYCLE) begin
          if (!avs_writedata[`WATCH_EN_BIT] ||
              (avs_writedata[`WATCH_LIM_MSB:0] != 15'h0000 &&
               avs_writedata[`WATCH_LIM_MSB:0] <= `WATCH_LIM_MAX))
            watch_cycle <= avs_writedata[15:0];
        end else if (avs_address == `REG_CONTROL) begin
          run <= avs_writedata[`CTL_RUN];
          parallel <= avs_writedata[`CTL_PARALLEL];
        end else if (avs_address == `REG_SCHED_PERIOD) begin
          sched_period <= avs_writedata[15:0];
        end else if (avs_address == `REG_EDGE_CFG) begin
          edge_cfg <= avs_writedata[IO_INTS-1:0];
        end else if (avs_address == `REG_REFRESH_CFG) begin
          special_refresh_off <= avs_writedata[3:0];
        end
      end
      if (halted)
        run <= 1'b0;
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    next_readdata = 32'h00000000;
    if (avs_address == `REG_MIN_CYCLE)
      next_readdata = {16'h0000, min_cycle};
    else if (avs_address == `REG_WATCH_CYCLE)
      next_readdata = {16'h0000, watch_cycle};
    else if (avs_address == `REG_MAX_DUR)
      next_readdata = max_dur;
    else if (avs_address == `REG_PRESENT_DUR)
      next_readdata = present_dur;
    else if (avs_address == `REG_AVG_DUR)
      next_readdata = hist_sum[34:`AVG_SHIFT];
    else if (avs_address == `REG_PERIPH_DUR)
      next_readdata = periph_dur;
    else if (avs_address == `REG_CONTROL)
      next_readdata = {30'h00000000, parallel, run};
    else if (avs_address == `REG_STATUS)
      next_readdata = {27'h0000000, state != S_IDLE && state != S_HALT, state == S_PAD,
        special_unit_error_flag, periph_overrun_flag, overrun_flag};
    else if (avs_address == `REG_SCHED_PERIOD)
      next_readdata = {16'h0000, sched_period};
    else if (avs_address == `REG_TASK)
      next_readdata = {23'h000000, task_req, task_num};
    else if (avs_address == `REG_EDGE_CFG)
      next_readdata = edge_cfg;
    else if (avs_address == `REG_REFRESH_CFG)
      next_readdata = {28'h0000000, special_refresh_off};
  end
endmodule
`default_nettype wire

// >>> verif/scan_cycle_checker_properties.sv
// Port-level checker for the cycle supervisor
// Assumes it is bound to the supervisor top; single mclk domain
`timescale 1ns/1ps
`default_nettype none
module scan_cycle_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic task_ack,
  input wire logic cycle_start,
  input wire logic halted,
  input wire logic task_req,
  input wire logic [7:0] task_num,
  input wire logic [3:0] refresh_allow
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // Bus answers after exactly one wait state, for one cycle
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait state");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address > 6'h2c
    |-> avs_readdata == 32'h0)
    else $error("unmapped read returned data");
  // A halted block starts no cycle and leaves halt only by a write
  AST_HALT_QUIET: assert property (halted |-> !cycle_start)
    else $error("cycle started while halted");
  AST_HALT_FALL: assert property ($fell(halted) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("halt left without a clearing write");
  AST_START_PULSE: assert property (cycle_start |=> !cycle_start)
    else $error("cycle start longer than one cycle");
  AST_TASK_HOLD: assert property (task_req && !task_ack |=> task_req && $stable(task_num))
    else $error("task request dropped or changed before acceptance");
  AST_REFRESH: assert property ($past(rst_b, 2) |->
    refresh_allow[0] && refresh_allow[2] && refresh_allow[3])
    else $error("cyclic refresh class disabled");
endmodule
bind scan_cycle_time_supervisor scan_cycle_checker chk_u (
  .mclk(mclk),
  .rst_b(rst_b),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .task_ack(task_ack),
  .cycle_start(cycle_start),
  .halted(halted),
  .task_req(task_req),
  .task_num(task_num),
  .refresh_allow(refresh_allow)
);
`default_nettype wire

// >>> verif/cycle_executor_model.sv
// Executor stand-in: ends each cycle and accepts interrupt tasks
// Assumes the supervisor's cycle_start and task_req in the mclk domain
`timescale 1ns/1ps
`default_nettype none
module cycle_executor_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cycle_start,
  input wire logic task_req,
  input wire logic [15:0] run_len,
  output logic periph_done,
  output logic task_ack
);
  logic [15:0] cnt;
  logic busy;
  // Servicing ends run_len clocks after each start; slow lengths trip the watch
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 16'h0000;
      busy <= 1'b0;
      periph_done <= 1'b0;
    end else begin
      periph_done <= busy && cnt == 16'h0001;
      if (cycle_start) begin
        busy <= 1'b1;
        cnt <= run_len;
      end else if (busy) begin
        cnt <= cnt - 16'h0001;
        busy <= cnt != 16'h0001;
      end
    end
  end
  // Accept each task once; pulse so a new request is not swallowed
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      task_ack <= 1'b0;
    end else begin
      task_ack <= task_req && !task_ack;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the cycle supervisor over Avalon-MM
// Assumes the executor model and TICK_CYCLES of 4 clocks per tick
`timescale 1ns/1ps
`default_nettype none
`include "scan_cycle_map.vh"
module tb;
  logic mclk, rst_b, avs_read, avs_write, avs_waitrequest, power_fail, ext_int;
  logic periph_done, task_ack, cycle_start, halted, task_req;
  logic program_done, special_busy;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, io_int;
  logic [7:0] ext_task, task_num;
  logic [3:0] refresh_allow;
  logic [15:0] run_len;
  logic [255:0] seen;
  int failures = 0;
  int check_count = 0;
  int g;
  logic [5:0] wa [6] = '{`REG_MIN_CYCLE, `REG_MIN_CYCLE, `REG_WATCH_CYCLE,
    `REG_WATCH_CYCLE, `REG_WATCH_CYCLE, 6'h30};
  logic [31:0] wd [6] = '{32'h7d01, 32'h7d00, 32'h8000, 32'h8fa1, 32'h8fa0, 32'hffffffff};
  logic [31:0] we [6] = '{32'h0, 32'h7d00, 32'h1, 32'h1, 32'h8fa0, 32'h0};

  scan_cycle_time_supervisor #(.TICK_CYCLES(4), .IO_INTS(32)) dut_u (
    .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .program_done(program_done), .periph_done(periph_done), .special_busy(special_busy),
    .power_fail(power_fail), .io_int(io_int), .ext_int(ext_int), .ext_task(ext_task),
    .task_ack(task_ack), .cycle_start(cycle_start), .halted(halted),
    .task_req(task_req), .task_num(task_num), .refresh_allow(refresh_allow));
  cycle_executor_model exec_u (.mclk(mclk), .rst_b(rst_b), .cycle_start(cycle_start),
    .task_req(task_req), .run_len(run_len), .periph_done(periph_done), .task_ack(task_ack));

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Record every task number handed over
  always @(posedge mclk) begin
    if (task_req === 1'b1 && task_ack === 1'b1) seen[task_num] <= 1'b1;
  end

  task summarize;
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Range compare; tick phase makes timings jitter by up to one tick
  task rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("Error t=%0t got=%h lo=%h hi=%h", $time, got, lo, hi);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 64) begin
      failures++;
      summarize;
    end
  endtask
  // Clocks until the given flag is seen high, bounded
  task wait_for(input int which, output int c);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while ((which ? halted : cycle_start) !== 1'b1 && c < 3000);
    if (c >= 3000) begin
      failures++;
      summarize;
    end
  endtask

  initial begin
    {rst_b, avs_read, avs_write, power_fail, ext_int, program_done, special_busy} = 7'h00;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    io_int = 32'h0;
    ext_task = 8'h00;
    run_len = 16'd20;
    seen = '0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    bus(1'b0, `REG_MIN_CYCLE, 32'h0);
    chk(q, 32'h0000);
    bus(1'b0, `REG_WATCH_CYCLE, 32'h0);
    chk(q, 32'h0001);
    chk({28'h0, refresh_allow}, 32'hf);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, wa[i], wd[i]);
      bus(1'b0, wa[i], 32'h0);
      chk(q, we[i]);
    end
    bus(1'b1, `REG_REFRESH_CFG, 32'h1);
    // Mask lands at the write edge, the output one edge later
    repeat (2) @(posedge mclk);
    chk({28'h0, refresh_allow}, 32'hd);
    bus(1'b1, `REG_WATCH_CYCLE, 32'h1);
    bus(1'b1, `REG_MIN_CYCLE, 32'h2);
    bus(1'b1, `REG_CONTROL, 32'h1);
    // Short work padded to 2 ms = 20 ticks = 80 clocks
    wait_for(0, g);
    wait_for(0, g);
    rng(g, 76, 86);
    // 40-tick work runs past the minimum unpadded
    run_len <= 16'd160;
    for (int i = 0; i < 10; i++) wait_for(0, g);
    rng(g, 160, 168);
    bus(1'b0, `REG_PRESENT_DUR, 32'h0);
    rng(q, 38, 42);
    bus(1'b0, `REG_MAX_DUR, 32'h0);
    rng(q, 38, 42);
    bus(1'b0, `REG_AVG_DUR, 32'h0);
    rng(q, 38, 42);
    // Every interrupt source at once, then a falling edge in both-edge mode
    ext_task <= 8'hff;
    {power_fail, ext_int} <= 2'b11;
    io_int <= 32'h3;
    repeat (3) @(posedge mclk);
    ext_int <= 1'b0;
    repeat (300) @(posedge mclk);
    chk({27'h0, seen[8'h01], seen[8'hff], seen[8'h02], seen[8'h03], seen[8'h64]}, 32'h1f);
    bus(1'b1, `REG_EDGE_CFG, 32'h2);
    seen <= '0;
    io_int <= 32'h0;
    repeat (200) @(posedge mclk);
    chk({30'h0, seen[8'h65], seen[8'h64]}, 32'h2);
    // Watch 10 ms = 100 ticks = 400 clocks against 150-tick work
    bus(1'b1, `REG_WATCH_CYCLE, 32'h8001);
    run_len <= 16'd600;
    wait_for(0, g);
    wait_for(1, g);
    rng(g, 400, 412);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk({31'h0, q[`ST_OVERRUN]}, 32'h1);
    bus(1'b1, `REG_CONTROL, 32'h10);
    repeat (3) @(posedge mclk);
    chk({31'h0, halted}, 32'h0);
    // Parallel mode: servicing timed apart, cycle ended by program only
    run_len <= 16'd40;
    bus(1'b1, `REG_CONTROL, 32'h3);
    wait_for(0, g);
    repeat (60) @(posedge mclk);
    {program_done, special_busy} <= 2'b11;
    @(posedge mclk);
    {program_done, special_busy} <= 2'b00;
    wait_for(0, g);
    bus(1'b0, `REG_PERIPH_DUR, 32'h0);
    rng(q, 9, 12);
    bus(1'b0, `REG_PRESENT_DUR, 32'h0);
    rng(q, 14, 17);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk({31'h0, q[`ST_SPECIAL_ERR]}, 32'h1);
    summarize;
  end
endmodule
`default_nettype wire
